//--- src/ncf_bus_cycle.sv
// One strobed byte cycle on the NAND pins: command, address, write data or read data
`include "ncf_cfg.svh"
module ncf_bus_cycle (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire ncf_pkg::ncf_req_s req,
  input wire logic [7:0] ioIn,
  output ncf_pkg::ncf_pins_s pins,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic done,
  output logic idle
);
  localparam logic [2:0] PhaseCyc = 3'(`NCF_PHASE_CYC);
  ncf_pkg::ncf_cyc_state_s s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rdValid = 1'b0;
    case (s_q.st)
      ncf_pkg::NCF_ST_IDLE:
      begin
        if (reqValid)
        begin
          s_d.req = req;
          s_d.st = ncf_pkg::NCF_ST_SETUP;
          s_d.pins.ceN = 1'b0;
          s_d.pins.cle = (req.kind == ncf_pkg::NCF_CYC_CMD);
          s_d.pins.ale = (req.kind == ncf_pkg::NCF_CYC_ADDR);
          s_d.pins.ioOut = req.data;
          s_d.pins.ioOe = (req.kind != ncf_pkg::NCF_CYC_RDATA);
        end
      end
      ncf_pkg::NCF_ST_SETUP:
      begin
        s_d.st = ncf_pkg::NCF_ST_LOW;
        s_d.cnt = PhaseCyc;
        if (s_q.req.kind == ncf_pkg::NCF_CYC_RDATA)
          s_d.pins.readStrobeN = 1'b0;
        else
          s_d.pins.weN = 1'b0;
      end
      ncf_pkg::NCF_ST_LOW:
      begin
        s_d.cnt = s_q.cnt - 3'h1;
        if (s_q.cnt == 3'h1)
        begin
          s_d.st = ncf_pkg::NCF_ST_HIGH;
          s_d.cnt = PhaseCyc;
          // Sample before the rising edge: data out is long valid by now
          if (s_q.req.kind == ncf_pkg::NCF_CYC_RDATA)
          begin
            s_d.rdData = ioIn;
            s_d.rdValid = 1'b1;
          end
          s_d.pins.weN = 1'b1;
          s_d.pins.readStrobeN = 1'b1;
        end
      end
      ncf_pkg::NCF_ST_HIGH:
      begin
        s_d.cnt = s_q.cnt - 3'h1;
        if (s_q.cnt == 3'h1)
        begin
          s_d.st = ncf_pkg::NCF_ST_GAP;
          s_d.pins.cle = 1'b0;
          s_d.pins.ale = 1'b0;
          s_d.pins.ioOe = 1'b0;
        end
      end
      default:
      begin
        s_d.st = ncf_pkg::NCF_ST_IDLE;
        s_d.done = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.pins.ceN <= 1'b1;
      s_q.pins.weN <= 1'b1;
      s_q.pins.readStrobeN <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign pins = s_q.pins;
  assign rdData = s_q.rdData;
  assign rdValid = s_q.rdValid;
  assign done = s_q.done;
  assign idle = (s_q.st == ncf_pkg::NCF_ST_IDLE);
endmodule

//--- src/ncf_cfg.svh
// Command codes, address layout and timing counts for the NAND host controller
`ifndef NCF_CFG_SVH
`define NCF_CFG_SVH
`define NCF_CMD_READ_LO 8'h00
`define NCF_CMD_READ_HI 8'h01
`define NCF_CMD_CB_DUMMY 8'h03
`define NCF_CMD_CONFIRM 8'h10
`define NCF_CMD_DUMMY_CONF 8'h11
`define NCF_CMD_READ_SPARE 8'h50
`define NCF_CMD_ERASE 8'h60
`define NCF_CMD_STATUS 8'h70
`define NCF_CMD_STATUS_MP 8'h71
`define NCF_CMD_PROGRAM 8'h80
`define NCF_CMD_CB_TARGET 8'h8A
`define NCF_CMD_READ_ID 8'h90
`define NCF_CMD_READ_ID2 8'h91
`define NCF_CMD_ERASE_CONF 8'hD0
`define NCF_CMD_RESET 8'hFF
`define NCF_ADDR_BITS 27
`define NCF_PAGE_BYTES 528
`define NCF_SPARE_START 512
`define NCF_PAGES_PER_BLOCK 32
`define NCF_BLOCKS 8192
`define NCF_PLANES 4
`define NCF_BLOCKS_PER_PLANE 2048
`define NCF_HALF_BIT 8
// Strobe phase length: 2 cycles of 40 ns = 80 ns covers 25 ns pulse and 45 ns cycle
`define NCF_PHASE_NS 80
`define NCF_CLK_NS 40
`define NCF_PHASE_CYC ((`NCF_PHASE_NS + `NCF_CLK_NS - 1) / `NCF_CLK_NS)
// WE high to read strobe low, least 60 ns
`define NCF_WHR_NS 60
`define NCF_WHR_CYC ((`NCF_WHR_NS + `NCF_CLK_NS - 1) / `NCF_CLK_NS)
// WE high to busy, at most 100 ns; wait this long before trusting ready
`define NCF_WB_NS 100
`define NCF_WB_CYC ((`NCF_WB_NS + `NCF_CLK_NS - 1) / `NCF_CLK_NS)
`endif

//--- src/ncf_host.sv
// NAND flash host controller: sequences commands, addresses and data onto the device pins
`include "ncf_cfg.svh"
module ncf_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire ncf_pkg::ncf_cmd_s cmd,
  output logic cmdReady,
  input wire logic [7:0] wrData,
  input wire logic wrValid,
  output logic wrReady,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic opDone,
  output logic busy,
  output logic nandCeN,
  output logic nandCle,
  output logic nandAle,
  output logic nandWeN,
  output logic readStrobeN,
  output logic [7:0] nandIoOut,
  output logic nandIoOe,
  input wire logic [7:0] nandIoIn,
  input wire logic nandReadyIn
);
  localparam logic [2:0] WbCyc = 3'(`NCF_WB_CYC);
  localparam logic [2:0] WhrCyc = 3'(`NCF_WHR_CYC);
  localparam logic [9:0] PageBytes = 10'(`NCF_PAGE_BYTES);

  ncf_pkg::ncf_seq_state_s s_q, s_d;
  ncf_pkg::ncf_pins_s cycPins, pins_q;
  ncf_pkg::ncf_req_s cycReq;
  logic cycValid;
  logic [7:0] cycRdData;
  logic cycRdValid;
  logic cycDone;
  logic cycIdle;
  logic [7:0] firstCmd;
  logic [7:0] secondCmd;
  logic [2:0] addrCount;
  logic [2:0] addrFirst;
  logic hasData;
  logic readData;
  logic waitsReady;
  logic [7:0] addrByte;

  ncf_bus_cycle u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .reqValid(cycValid),
    .req(cycReq),
    .ioIn(nandIoIn),
    .pins(cycPins),
    .rdData(cycRdData),
    .rdValid(cycRdValid),
    .done(cycDone),
    .idle(cycIdle)
  );

  // Opcode table: every command byte sent is one of the defined codes
  always_comb
  begin
    firstCmd = `NCF_CMD_STATUS;
    secondCmd = `NCF_CMD_CONFIRM;
    addrCount = 3'h4;
    addrFirst = 3'h0;
    hasData = 1'b0;
    readData = 1'b0;
    waitsReady = 1'b0;
    case (s_q.cmd.op)
      ncf_pkg::NCF_OP_READ:
      begin
        // Half select bit picks 00h or 01h
        firstCmd = s_q.cmd.addr[`NCF_HALF_BIT] ? `NCF_CMD_READ_HI : `NCF_CMD_READ_LO;
        readData = 1'b1;
        waitsReady = 1'b1;
      end
      ncf_pkg::NCF_OP_READ_SPARE:
      begin
        firstCmd = `NCF_CMD_READ_SPARE;
        readData = 1'b1;
        waitsReady = 1'b1;
      end
      ncf_pkg::NCF_OP_READ_ID:
      begin
        firstCmd = `NCF_CMD_READ_ID;
        addrCount = 3'h1;
        readData = 1'b1;
      end
      ncf_pkg::NCF_OP_RESET:
      begin
        firstCmd = `NCF_CMD_RESET;
        addrCount = 3'h0;
        waitsReady = 1'b1;
      end
      ncf_pkg::NCF_OP_PROGRAM, ncf_pkg::NCF_OP_PROGRAM_DUMMY:
      begin
        firstCmd = `NCF_CMD_PROGRAM;
        secondCmd = (s_q.cmd.op == ncf_pkg::NCF_OP_PROGRAM) ? `NCF_CMD_CONFIRM : `NCF_CMD_DUMMY_CONF;
        hasData = 1'b1;
        waitsReady = 1'b1;
      end
      ncf_pkg::NCF_OP_CB_READ, ncf_pkg::NCF_OP_CB_READ_DUMMY:
      begin
        firstCmd = (s_q.cmd.op == ncf_pkg::NCF_OP_CB_READ) ? `NCF_CMD_READ_LO : `NCF_CMD_CB_DUMMY;
        waitsReady = 1'b1;
      end
      ncf_pkg::NCF_OP_CB_WRITE, ncf_pkg::NCF_OP_CB_WRITE_DUMMY:
      begin
        firstCmd = `NCF_CMD_CB_TARGET;
        secondCmd = (s_q.cmd.op == ncf_pkg::NCF_OP_CB_WRITE) ? `NCF_CMD_CONFIRM : `NCF_CMD_DUMMY_CONF;
        waitsReady = 1'b1;
      end
      ncf_pkg::NCF_OP_ERASE, ncf_pkg::NCF_OP_ERASE_QUEUE:
      begin
        firstCmd = `NCF_CMD_ERASE;
        secondCmd = `NCF_CMD_ERASE_CONF;
        addrFirst = 3'h1;
        waitsReady = (s_q.cmd.op == ncf_pkg::NCF_OP_ERASE);
      end
      ncf_pkg::NCF_OP_STATUS_MP:
      begin
        firstCmd = `NCF_CMD_STATUS_MP;
        addrCount = 3'h0;
        readData = 1'b1;
      end
      default:
      begin
        addrCount = 3'h0;
        readData = 1'b1;
      end
    endcase
  end

  // Byte layout of the four address cycles; bit 8 never travels
  always_comb
  begin
    case (s_q.addrIdx)
      3'h0: addrByte = s_q.cmd.addr[7:0];
      3'h1: addrByte = s_q.cmd.addr[16:9];
      3'h2: addrByte = s_q.cmd.addr[24:17];
      default: addrByte = {6'h00, s_q.cmd.addr[26:25]};
    endcase
  end

  always_comb
  begin
    cycValid = 1'b0;
    cycReq = '0;
    case (s_q.sq)
      ncf_pkg::NCF_SQ_CMD1:
      begin
        cycValid = !s_q.issued;
        cycReq = '{ncf_pkg::NCF_CYC_CMD, firstCmd};
      end
      ncf_pkg::NCF_SQ_ADDR:
      begin
        cycValid = !s_q.issued;
        cycReq = '{ncf_pkg::NCF_CYC_ADDR, (s_q.cmd.op == ncf_pkg::NCF_OP_READ_ID) ? 8'h00 : addrByte};
      end
      ncf_pkg::NCF_SQ_DATA:
      begin
        cycValid = !s_q.issued && (readData || wrValid);
        cycReq = '{readData ? ncf_pkg::NCF_CYC_RDATA : ncf_pkg::NCF_CYC_WDATA, wrData};
      end
      ncf_pkg::NCF_SQ_CMD2:
      begin
        cycValid = !s_q.issued;
        cycReq = '{ncf_pkg::NCF_CYC_CMD, secondCmd};
      end
      default:
      begin
        cycValid = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.opDone = 1'b0;
    s_d.rdValid = cycRdValid;
    s_d.rdData = cycRdValid ? cycRdData : s_q.rdData;
    s_d.wrReady = 1'b0;
    if (cycValid && cycIdle)
      s_d.issued = 1'b1;
    if (cycDone)
      s_d.issued = 1'b0;
    case (s_q.sq)
      ncf_pkg::NCF_SQ_IDLE:
      begin
        if (cmdValid)
        begin
          s_d.cmd = cmd;
          s_d.sq = ncf_pkg::NCF_SQ_CMD1;
          s_d.busy = 1'b1;
        end
      end
      ncf_pkg::NCF_SQ_CMD1:
      begin
        if (cycDone)
        begin
          s_d.addrIdx = addrFirst;
          s_d.byteCnt = (s_q.cmd.len == 10'h000 || s_q.cmd.len > PageBytes) ? PageBytes : s_q.cmd.len;
          if (addrCount != 3'h0)
            s_d.sq = ncf_pkg::NCF_SQ_ADDR;
          else if (readData)
            s_d.sq = ncf_pkg::NCF_SQ_READOUT;
          else
            s_d.sq = ncf_pkg::NCF_SQ_WAITBUSY;
          s_d.waitCnt = readData ? WhrCyc : WbCyc;
        end
      end
      ncf_pkg::NCF_SQ_ADDR:
      begin
        if (cycDone)
        begin
          s_d.addrIdx = s_q.addrIdx + 3'h1;
          if (s_q.addrIdx + 3'h1 >= addrCount)
          begin
            s_d.waitCnt = (readData && !waitsReady) ? WhrCyc : WbCyc;
            if (hasData)
              s_d.sq = ncf_pkg::NCF_SQ_DATA;
            else if (readData && !waitsReady)
              s_d.sq = ncf_pkg::NCF_SQ_READOUT;
            else if (s_q.cmd.op == ncf_pkg::NCF_OP_ERASE_QUEUE)
              s_d.sq = ncf_pkg::NCF_SQ_DONE;
            else if (s_q.cmd.op == ncf_pkg::NCF_OP_CB_WRITE || s_q.cmd.op == ncf_pkg::NCF_OP_CB_WRITE_DUMMY
                     || s_q.cmd.op == ncf_pkg::NCF_OP_ERASE)
              s_d.sq = ncf_pkg::NCF_SQ_CMD2;
            else
              s_d.sq = ncf_pkg::NCF_SQ_WAITBUSY;
          end
        end
      end
      ncf_pkg::NCF_SQ_READOUT:
      begin
        s_d.waitCnt = s_q.waitCnt - 3'h1;
        if (s_q.waitCnt == 3'h1)
          s_d.sq = ncf_pkg::NCF_SQ_DATA;
      end
      ncf_pkg::NCF_SQ_DATA:
      begin
        s_d.wrReady = cycValid && cycIdle && !readData;
        if (cycDone)
        begin
          s_d.byteCnt = s_q.byteCnt - 10'h001;
          if (s_q.byteCnt == 10'h001 || s_q.cmd.op == ncf_pkg::NCF_OP_STATUS
              || s_q.cmd.op == ncf_pkg::NCF_OP_STATUS_MP)
            s_d.sq = hasData ? ncf_pkg::NCF_SQ_CMD2 : ncf_pkg::NCF_SQ_DONE;
        end
      end
      ncf_pkg::NCF_SQ_CMD2:
      begin
        if (cycDone)
        begin
          s_d.sq = ncf_pkg::NCF_SQ_WAITBUSY;
          s_d.waitCnt = WbCyc;
        end
      end
      ncf_pkg::NCF_SQ_WAITBUSY:
      begin
        s_d.waitCnt = s_q.waitCnt - 3'h1;
        if (s_q.waitCnt == 3'h1)
          s_d.sq = ncf_pkg::NCF_SQ_WAITRDY;
      end
      ncf_pkg::NCF_SQ_WAITRDY:
      begin
        // Nothing else is sent until ready returns high
        if (nandReadyIn)
        begin
          if (readData)
          begin
            s_d.sq = ncf_pkg::NCF_SQ_READOUT;
            s_d.waitCnt = 3'h1;
          end
          else
            s_d.sq = ncf_pkg::NCF_SQ_DONE;
        end
      end
      default:
      begin
        s_d.sq = ncf_pkg::NCF_SQ_IDLE;
        s_d.busy = 1'b0;
        s_d.opDone = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      pins_q <= '0;
      pins_q.ceN <= 1'b1;
      pins_q.weN <= 1'b1;
      pins_q.readStrobeN <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
      pins_q <= cycPins;
    end
  end

  // Pins are retimed once more so every pin output is a flop; all strobes shift together
  assign nandCeN = pins_q.ceN;
  assign nandCle = pins_q.cle;
  assign nandAle = pins_q.ale;
  assign nandWeN = pins_q.weN;
  assign readStrobeN = pins_q.readStrobeN;
  assign nandIoOut = pins_q.ioOut;
  assign nandIoOe = pins_q.ioOe;
  assign cmdReady = !s_q.busy;
  assign busy = s_q.busy;
  assign opDone = s_q.opDone;
  assign rdData = s_q.rdData;
  assign rdValid = s_q.rdValid;
  assign wrReady = s_q.wrReady;
endmodule

//--- src/ncf_pkg.sv
// Types shared by the NAND host controller
package ncf_pkg;
  typedef enum logic [1:0] {NCF_CYC_CMD, NCF_CYC_ADDR, NCF_CYC_WDATA, NCF_CYC_RDATA} ncf_cyc_e;
  typedef struct packed {
    ncf_cyc_e kind;
    logic [7:0] data;
  } ncf_req_s;
  typedef struct packed {
    logic ceN;
    logic cle;
    logic ale;
    logic weN;
    logic readStrobeN;
    logic [7:0] ioOut;
    logic ioOe;
  } ncf_pins_s;
  typedef enum logic [2:0] {NCF_ST_IDLE, NCF_ST_SETUP, NCF_ST_LOW, NCF_ST_HIGH, NCF_ST_GAP} ncf_st_e;
  typedef struct packed {
    ncf_st_e st;
    logic [2:0] cnt;
    ncf_req_s req;
    ncf_pins_s pins;
    logic [7:0] rdData;
    logic rdValid;
    logic done;
  } ncf_cyc_state_s;
  typedef enum logic [3:0] {
    NCF_SQ_IDLE, NCF_SQ_CMD1, NCF_SQ_ADDR, NCF_SQ_DATA, NCF_SQ_CMD2,
    NCF_SQ_WAITBUSY, NCF_SQ_WAITRDY, NCF_SQ_READOUT, NCF_SQ_DONE
  } ncf_seq_e;
  // Operation requested by the user side
  typedef enum logic [3:0] {
    NCF_OP_READ, NCF_OP_READ_SPARE, NCF_OP_READ_ID, NCF_OP_RESET, NCF_OP_PROGRAM,
    NCF_OP_PROGRAM_DUMMY, NCF_OP_CB_READ, NCF_OP_CB_WRITE, NCF_OP_CB_WRITE_DUMMY,
    NCF_OP_ERASE, NCF_OP_ERASE_QUEUE, NCF_OP_STATUS, NCF_OP_STATUS_MP, NCF_OP_CB_READ_DUMMY
  } ncf_op_e;
  typedef struct packed {
    ncf_op_e op;
    logic [26:0] addr;
    logic [9:0] len;
  } ncf_cmd_s;
  typedef struct packed {
    ncf_seq_e sq;
    ncf_cmd_s cmd;
    logic [2:0] addrIdx;
    logic [9:0] byteCnt;
    logic [2:0] waitCnt;
    logic issued;
    logic busy;
    logic opDone;
    logic wrReady;
    logic [7:0] rdData;
    logic rdValid;
  } ncf_seq_state_s;
endpackage

//--- verification/ncf_dev_model.sv
// Behavioural NAND device answering the host controller's pins
module ncf_dev_model (
  input wire logic ceN,
  input wire logic cle,
  input wire logic ale,
  input wire logic weN,
  input wire logic readStrobeN,
  input wire logic [7:0] hostIo,
  input wire logic slowDev,
  output logic [7:0] devIo,
  output logic readyOut
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] log[$];
  logic [1:0] plane[$];
  logic [9:0] col = 10'h000;
  logic half = 1'b0;
  logic statMode = 1'b0;
  logic [7:0] lastCmd = 8'hFF;
  int addrN = 9;
  int ignored = 0;
  initial readyOut = 1'b1;
  initial devIo = 8'h00;
  function automatic logic [7:0] dataAt(input logic [9:0] c);
    return c[7:0] ^ (c[8] ? 8'hC3 : 8'h5A);
  endfunction
  // Busy shows up 50 ns after the strobe, inside the host's blind window
  task automatic go_busy();
    fork
      begin
        #50 readyOut = 1'b0;
        #(slowDev ? 4000 : 400) readyOut = 1'b1;
      end
    join_none
  endtask
  always @(posedge weN)
  begin
    if (!ceN && cle && !readyOut && !(hostIo inside {8'h70, 8'h71, 8'hFF}))
      ignored++;
    else if (!ceN && cle)
    begin
      log.push_back({2'b01, hostIo});
      lastCmd = hostIo;
      addrN = 0;
      statMode = hostIo inside {8'h70, 8'h71};
      if (hostIo inside {8'h00, 8'h01})
        half = hostIo[0];
      if (hostIo inside {8'h10, 8'h11, 8'hD0, 8'hFF})
        go_busy();
    end
    else if (!ceN && ale && addrN < ((lastCmd == 8'h60) ? 3 : 4))
    begin
      log.push_back({2'b10, hostIo});
      if (addrN == 0)
        col = (lastCmd == 8'h50) ? {6'h20, hostIo[3:0]} : {1'b0, half, hostIo};
      // Byte with A9-16 holds block bits A15:A14, which pick the plane
      if (addrN == ((lastCmd == 8'h60) ? 0 : 1))
        plane.push_back(hostIo[6:5]);
      addrN++;
      if (addrN == 4 && lastCmd inside {8'h00, 8'h01, 8'h03, 8'h50})
        go_busy();
    end
    else if (!ceN && !ale)
      log.push_back({2'b00, hostIo});
  end
  always @(negedge readStrobeN)
  begin
    devIo <= statMode ? 8'hC0 : dataAt(col);
    col = (col == 10'd527) ? 10'd0 : col + 10'd1;
    half = 1'b0;
  end
  // Released bus shows the inverse so a late sample cannot pass by luck
  always @(posedge readStrobeN)
    devIo <= ~devIo;
endmodule

//--- verification/ncf_host_props.sv
// Pin-level checker for the NAND host controller
module ncf_host_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic opDone,
  input wire logic nandCeN,
  input wire logic nandCle,
  input wire logic nandAle,
  input wire logic nandWeN,
  input wire logic readStrobeN,
  input wire logic [7:0] nandIoOut,
  input wire logic nandIoOe,
  input wire logic nandReadyIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wePrev_q;
  logic [2:0] addrN_q;
  logic [7:0] lastCmd_q;
  logic weRise;
  // Erase carries only row bytes, so its last address byte is the third
  logic [2:0] lastIdx;
  assign weRise = nandWeN && !wePrev_q;
  assign lastIdx = (lastCmd_q == 8'h60) ? 3'h2 : 3'h3;
  always_ff @(posedge clk)
  begin
    wePrev_q <= rst_n ? nandWeN : 1'b1;
    if (!rst_n || (weRise && nandCle))
      addrN_q <= 3'h0;
    else if (weRise && nandAle)
      addrN_q <= addrN_q + 3'h1;
    if (!rst_n)
      lastCmd_q <= 8'hFF;
    else if (weRise && nandCle)
      lastCmd_q <= nandIoOut;
  end
  a_strobe_select: assert property (@(posedge clk) disable iff (!rst_n) !nandWeN |-> !nandCeN)
    else $error("write strobe low without chip select");
  a_we_pulse: assert property (@(posedge clk) disable iff (!rst_n) $fell(nandWeN) |=> !nandWeN ##1 nandWeN)
    else $error("write strobe pulse not two cycles");
  a_data_stable: assert property (@(posedge clk) disable iff (!rst_n) $rose(nandWeN) |-> $stable(nandIoOut) && nandIoOe)
    else $error("bus byte not held across write strobe rise");
  a_latch_exclusive: assert property (@(posedge clk) disable iff (!rst_n) !(nandCle && nandAle))
    else $error("command and address latch both high");
  a_read_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !readStrobeN |-> nandWeN && !nandIoOe && !nandCle && !nandAle)
    else $error("read strobe overlaps a write cycle");
  a_rd_pulse: assert property (@(posedge clk) disable iff (!rst_n) $fell(readStrobeN) |=> !readStrobeN ##1 readStrobeN)
    else $error("read strobe pulse not two cycles");
  a_legal_code: assert property (@(posedge clk) disable iff (!rst_n) weRise && nandCle |-> nandIoOut inside
    {8'h00, 8'h01, 8'h03, 8'h10, 8'h11, 8'h50, 8'h60, 8'h70, 8'h71, 8'h80, 8'h8A, 8'h90, 8'h91, 8'hD0, 8'hFF})
    else $error("undefined command code issued");
  a_addr_top: assert property (@(posedge clk) disable iff (!rst_n)
    weRise && nandAle && addrN_q == lastIdx |-> nandIoOut[7:2] == 6'h00)
    else $error("unused bits of last address byte not low");
  a_addr_count: assert property (@(posedge clk) disable iff (!rst_n) weRise && nandAle |-> addrN_q <= lastIdx)
    else $error("too many address bytes");
  a_busy_cmds: assert property (@(posedge clk) disable iff (!rst_n)
    weRise && nandCle && !nandReadyIn |-> nandIoOut inside {8'h70, 8'h71, 8'hFF})
    else $error("command other than status or reset while device busy");
  a_done_ready: assert property (@(posedge clk) disable iff (!rst_n) opDone |-> nandReadyIn)
    else $error("operation done while device busy");
endmodule
bind ncf_host ncf_host_props u_props (.clk, .rst_n, .opDone, .nandCeN, .nandCle, .nandAle, .nandWeN, .readStrobeN,
  .nandIoOut, .nandIoOe, .nandReadyIn);

//--- verification/ncf_host_tb.sv
// Self-checking bench for the NAND host controller against a behavioural device
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module ncf_host_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid = 1'b0;
  ncf_pkg::ncf_cmd_s cmd = '0;
  logic [7:0] wrData = 8'h00;
  logic wrValid = 1'b0;
  logic slowDev = 1'b0;
  logic cmdReady, wrReady, rdValid, opDone, busy, nandCeN, nandCle, nandAle, nandWeN, readStrobeN, nandIoOe;
  logic nandReadyIn;
  logic [7:0] rdData, nandIoOut, nandIoIn;
  int n_fail = 0;
  int compares = 0;
  logic [9:0] ex[$];
  logic [7:0] rdq[$];
  always #20 clk = ~clk;
  ncf_host dut (.clk, .rst_n, .cmdValid, .cmd, .cmdReady, .wrData, .wrValid, .wrReady, .rdData, .rdValid, .opDone,
    .busy, .nandCeN, .nandCle, .nandAle, .nandWeN, .readStrobeN, .nandIoOut, .nandIoOe, .nandIoIn, .nandReadyIn);
  ncf_dev_model dev (.ceN(nandCeN), .cle(nandCle), .ale(nandAle), .weN(nandWeN), .readStrobeN(readStrobeN),
    .hostIo(nandIoOut), .slowDev(slowDev), .devIo(nandIoIn), .readyOut(nandReadyIn));
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [7:0] expByte(input logic [9:0] c);
    return c[7:0] ^ (c[8] ? 8'hC3 : 8'h5A);
  endfunction
  function automatic void ec(input logic [7:0] c);
    ex.push_back({2'b01, c});
  endfunction
  // Row-only form is what block erase sends
  function automatic void ea(input logic [26:0] a, input bit rowOnly);
    if (!rowOnly)
      ex.push_back({2'b10, a[7:0]});
    ex.push_back({2'b10, a[16:9]});
    ex.push_back({2'b10, a[24:17]});
    ex.push_back({2'b10, 6'h00, a[26:25]});
  endfunction
  function automatic void ed(input int n);
    for (int i = 0; i < n; i++)
      ex.push_back({2'b00, 8'h30 + 8'(i)});
  endfunction
  task automatic run_op(input ncf_pkg::ncf_op_e op, input logic [26:0] a, input logic [9:0] n);
    int k;
    cmd = '{op: op, addr: a, len: n};
    cmdValid = 1'b1;
    wrValid = op inside {ncf_pkg::NCF_OP_PROGRAM, ncf_pkg::NCF_OP_PROGRAM_DUMMY};
    wrData = 8'h30;
    for (k = 0; k < 200 && cmdReady !== 1'b1; k++)
      @(negedge clk);
    @(negedge clk);
    cmdValid = 1'b0;
    for (k = 0; k < 20000 && opDone !== 1'b1; k++)
    begin
      @(negedge clk);
      if (rdValid === 1'b1)
        rdq.push_back(rdData);
      if (wrReady === 1'b1)
        wrData = wrData + 8'h01;
    end
    wrValid = 1'b0;
    `CHK("opDone", 1'b1, opDone)
  endtask
  task automatic chk_log(input string nm);
    `CHK(nm, ex.size(), dev.log.size())
    foreach (ex[i])
      if (i < dev.log.size()) `CHK(nm, ex[i], dev.log[i])
    ex.delete();
    dev.log.delete();
    dev.plane.delete();
  endtask
  task automatic chk_rd(input logic [9:0] c, input int n);
    `CHK("rdCount", n, rdq.size())
    foreach (rdq[i]) `CHK("rdData", expByte(c + 10'(i)), rdq[i])
    rdq.delete();
  endtask
  task automatic t_read();
    logic [26:0] a = 27'h6B3C1D5;
    slowDev = 1'b1;
    run_op(ncf_pkg::NCF_OP_READ, a, 10'd4);
    ec(8'h01);
    ea(a, 0);
    chk_log("readHi");
    chk_rd(10'h1D5, 4);
    slowDev = 1'b0;
    run_op(ncf_pkg::NCF_OP_READ, a & ~27'h100, 10'd2);
    ec(8'h00);
    ea(a & ~27'h100, 0);
    chk_log("readLo");
    chk_rd(10'h0D5, 2);
  endtask
  task automatic t_program();
    logic [26:0] a = 27'h0123400;
    run_op(ncf_pkg::NCF_OP_PROGRAM_DUMMY, a, 10'd2);
    run_op(ncf_pkg::NCF_OP_PROGRAM, a + 27'h8000, 10'd3);
    run_op(ncf_pkg::NCF_OP_STATUS_MP, '0, 10'd1);
    ec(8'h80);
    ea(a, 0);
    ed(2);
    ec(8'h11);
    ec(8'h80);
    ea(a + 27'h8000, 0);
    ed(3);
    ec(8'h10);
    ec(8'h71);
    `CHK("planes", 4'h8, {dev.plane[1], dev.plane[0]})
    chk_log("program");
    `CHK("status", 8'hC0, rdq[0])
    rdq.delete();
  endtask
  task automatic t_erase();
    run_op(ncf_pkg::NCF_OP_ERASE_QUEUE, 27'h0004000, 10'd0);
    run_op(ncf_pkg::NCF_OP_ERASE, 27'h0008000, 10'd0);
    run_op(ncf_pkg::NCF_OP_STATUS_MP, '0, 10'd1);
    run_op(ncf_pkg::NCF_OP_ERASE, 27'h000C000, 10'd0);
    run_op(ncf_pkg::NCF_OP_STATUS, '0, 10'd1);
    ec(8'h60);
    ea(27'h0004000, 1);
    ec(8'h60);
    ea(27'h0008000, 1);
    ec(8'hD0);
    ec(8'h71);
    ec(8'h60);
    ea(27'h000C000, 1);
    ec(8'hD0);
    ec(8'h70);
    `CHK("planes", 6'h39, {dev.plane[2], dev.plane[1], dev.plane[0]})
    chk_log("erase");
    `CHK("status", 8'hC0, rdq[0])
    `CHK("status", 8'hC0, rdq[1])
    rdq.delete();
  endtask
  task automatic t_copyback();
    run_op(ncf_pkg::NCF_OP_CB_READ_DUMMY, 27'h0014000, 10'd0);
    run_op(ncf_pkg::NCF_OP_CB_WRITE_DUMMY, 27'h0024000, 10'd0);
    run_op(ncf_pkg::NCF_OP_CB_READ, 27'h0018000, 10'd0);
    run_op(ncf_pkg::NCF_OP_CB_WRITE, 27'h0028000, 10'd0);
    ec(8'h03);
    ea(27'h0014000, 0);
    ec(8'h8A);
    ea(27'h0024000, 0);
    ec(8'h11);
    ec(8'h00);
    ea(27'h0018000, 0);
    ec(8'h8A);
    ea(27'h0028000, 0);
    ec(8'h10);
    `CHK("cbPlanes", 8'hA5, {dev.plane[3], dev.plane[2], dev.plane[1], dev.plane[0]})
    chk_log("copyBack");
    `CHK("cbReads", 0, rdq.size())
  endtask
  task automatic t_misc();
    run_op(ncf_pkg::NCF_OP_RESET, '0, 10'd0);
    run_op(ncf_pkg::NCF_OP_READ_ID, '0, 10'd2);
    chk_rd(10'd0, 2);
    run_op(ncf_pkg::NCF_OP_READ_SPARE, 27'h0012000, 10'd3);
    chk_rd(10'd512, 3);
    ec(8'hFF);
    ec(8'h90);
    ex.push_back({2'b10, 8'h00});
    ec(8'h50);
    ea(27'h0012000, 0);
    chk_log("misc");
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_read();
    t_program();
    t_erase();
    t_copyback();
    t_misc();
    `CHK("ignored", 0, dev.ignored)
    test_done();
  end
  initial
  begin
    #3000000;
    n_fail++;
    test_done();
  end
endmodule
